// File: rtl/vc0_res_pkg.sv
// package: offsets, field layout, reset values and shared types for the vc0 resource registers
package vc0_res_pkg;

  // register byte offsets
  localparam logic [11:0] OFF_CAP = 12'h150;
  localparam logic [11:0] OFF_CTRL = 12'h154;
  localparam logic [11:0] OFF_STAT = 12'h158;

  // capability word fields
  localparam logic [7:0] CAP_PORT_ARB_RST = 8'h09;
  localparam logic [6:0] CAP_MAX_SLOTS_RST = 7'h7F;
  localparam logic [7:0] CAP_TBL_OFFSET_RST = 8'h04;
  localparam int CAP_ADV_SW_BIT = 14;
  localparam int CAP_SNOOP_BIT = 15;

  // control word fields
  localparam int CTRL_LOAD_BIT = 16;
  localparam int CTRL_SEL_LSB = 17;
  localparam int CTRL_EN_BIT = 31;
  localparam logic [7:0] CTRL_TCMAP_RST = 8'hFF;
  localparam logic CTRL_EN_RST = 1'b1;
  localparam logic [2:0] VC_ID_VAL = 3'h0;

  // status word fields
  localparam int STAT_TBL_BIT = 16;
  localparam int STAT_NEG_BIT = 17;

  // table load duration in cycles
  localparam int TBL_LOAD_CYCLES = 16;
  localparam logic [31:0] RD_UNMAPPED = 32'h0000_0000;

  // arbitration schemes allowed on this channel
  typedef enum logic [2:0] {
    ARB_HW_FIXED = 3'b000,
    ARB_WRR128 = 3'b011
  } arb_sel_t;

  // control state handed to the arbitration datapath
  typedef struct packed {
    logic vc_enable;
    arb_sel_t arb_sel;
    logic [7:0] tc_map;
  } vc_ctrl_t;

endpackage

// File: rtl/vc0_resource_regs.sv
// vc0 resource capability, control and status registers on an avalon-mm slave
//
// Function
// - arbitration capability reads 09h in bits 7:0
// - no time-based wrr on this channel
// - advanced-switching-only bit 14 reads zero
// - snoop rejection bit 15 reads zero
// - max time slots bits 22:16 read 7Fh
// - table offset bits 31:24 read 04h
// - tc map bits 7:0 writable, reset FFh
// - load bit 16 starts table load, reads zero
// - arb select: only 000b/011b, others become 000b
// - channel id bits 26:24 read 000b
// - enable bit 31 writable, resets one
// - table status set on table entry write
// - table status clears after load completes
// - negotiation pending bit 17 tracks negotiation
`timescale 1ns/1ps
module vc0_resource_regs
  import vc0_res_pkg::*;
#(
  parameter int LOAD_CYCLES = TBL_LOAD_CYCLES,
  parameter logic [7:0] TCMAP_PRELOAD = CTRL_TCMAP_RST
) (
  input wire logic clk,
  input wire logic resetn,
  input wire logic [11:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic tbl_entry_write,
  input wire logic neg_pending_in,
  output vc_ctrl_t vc_ctrl,
  output logic tbl_load_pulse
);

  ////////////////////////////////////////////////////////////////////////////
  // decode helpers

  // fold an unsupported arbitration scheme back to the default
  function automatic arb_sel_t legal_sel(input logic [2:0] raw);
    if (raw == ARB_WRR128) begin
      legal_sel = ARB_WRR128;
    end else begin
      legal_sel = ARB_HW_FIXED;
    end
  endfunction

  // merge write data under byte enables
  function automatic logic [31:0] be_merge(input logic [31:0] old, input logic [31:0] wd,
                                           input logic [3:0] be);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        r[i*8 +: 8] = wd[i*8 +: 8];
      end
    end
    return r;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // bus handshake: one wait cycle, answer on the second edge

  logic ack_q;
  logic req;
  logic take;
  assign req = avs_read | avs_write;
  assign take = req & ack_q;

  // waitrequest low exactly one cycle per access, giving registered read data
  always_ff @(posedge clk) begin
    if (!resetn) begin
      ack_q <= 1'b0;
    end else begin
      ack_q <= req & ~ack_q;
    end
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      avs_waitrequest <= 1'b1;
    end else begin
      avs_waitrequest <= ~(req & ~ack_q);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // control register

  logic [7:0] tcmap_q;
  arb_sel_t sel_q;
  logic en_q;
  logic ctrl_wr;
  logic [31:0] ctrl_img;
  logic [31:0] ctrl_new;
  assign ctrl_wr = take & avs_write & (avs_address == OFF_CTRL);

  // readback image; load bit and reserved bits always zero
  always_comb begin
    ctrl_img = 32'h0000_0000;
    ctrl_img[7:0] = tcmap_q;
    ctrl_img[CTRL_LOAD_BIT] = 1'b0;
    ctrl_img[CTRL_SEL_LSB +: 3] = sel_q;
    ctrl_img[26:24] = VC_ID_VAL;
    ctrl_img[CTRL_EN_BIT] = en_q;
  end
  assign ctrl_new = be_merge(ctrl_img, avs_writedata, avs_byteenable);

  // writable control fields
  always_ff @(posedge clk) begin
    if (!resetn) begin
      tcmap_q <= TCMAP_PRELOAD;
      sel_q <= ARB_HW_FIXED;
      en_q <= CTRL_EN_RST;
    end else if (ctrl_wr) begin
      tcmap_q <= ctrl_new[7:0];
      sel_q <= legal_sel(ctrl_new[CTRL_SEL_LSB +: 3]);
      en_q <= ctrl_new[CTRL_EN_BIT];
    end
  end

  // load strobe, one cycle, only if the lane holding bit 16 is enabled
  logic load_q;
  always_ff @(posedge clk) begin
    if (!resetn) begin
      load_q <= 1'b0;
    end else begin
      load_q <= ctrl_wr & avs_byteenable[2] & avs_writedata[CTRL_LOAD_BIT];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // table loader and status

  logic ld_busy;
  logic ld_done;
  vc0_tbl_loader #(
    .LOAD_CYCLES(LOAD_CYCLES)
  ) u_loader (
    .clk(clk),
    .resetn(resetn),
    .start(load_q),
    .busy(ld_busy),
    .done(ld_done)
  );

  // table status: entry write wins over a completing load
  logic tbl_stat_q;
  always_ff @(posedge clk) begin
    if (!resetn) begin
      tbl_stat_q <= 1'b0;
    end else if (tbl_entry_write) begin
      tbl_stat_q <= 1'b1;
    end else if (ld_done) begin
      tbl_stat_q <= 1'b0;
    end
  end

  // negotiation flag comes from the link layer on this same clock
  logic neg_q;
  always_ff @(posedge clk) begin
    if (!resetn) begin
      neg_q <= 1'b0;
    end else begin
      neg_q <= neg_pending_in;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // read mux and outputs

  logic [31:0] cap_img;
  logic [31:0] stat_img;
  always_comb begin
    cap_img = 32'h0000_0000;
    cap_img[7:0] = CAP_PORT_ARB_RST;
    cap_img[CAP_ADV_SW_BIT] = 1'b0;
    cap_img[CAP_SNOOP_BIT] = 1'b0;
    cap_img[22:16] = CAP_MAX_SLOTS_RST;
    cap_img[31:24] = CAP_TBL_OFFSET_RST;
    stat_img = 32'h0000_0000;
    stat_img[STAT_TBL_BIT] = tbl_stat_q;
    stat_img[STAT_NEG_BIT] = neg_q;
  end

  // read data registered on the first edge, one edge before the answering edge
  always_ff @(posedge clk) begin
    if (!resetn) begin
      avs_readdata <= 32'h0000_0000;
    end else if (avs_read & ~ack_q) begin
      case (avs_address)
        OFF_CAP: avs_readdata <= cap_img;
        OFF_CTRL: avs_readdata <= ctrl_img;
        OFF_STAT: avs_readdata <= stat_img;
        default: avs_readdata <= RD_UNMAPPED; // unmapped reads zero
      endcase
    end
  end

  // control to the datapath, registered
  always_ff @(posedge clk) begin
    if (!resetn) begin
      vc_ctrl <= '{vc_enable: CTRL_EN_RST, arb_sel: ARB_HW_FIXED, tc_map: TCMAP_PRELOAD};
      tbl_load_pulse <= 1'b0;
    end else begin
      vc_ctrl <= '{vc_enable: en_q, arb_sel: sel_q, tc_map: tcmap_q};
      tbl_load_pulse <= load_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // assertions

  sequence s_load_write;
    ctrl_wr && avs_byteenable[2] && avs_writedata[CTRL_LOAD_BIT];
  endsequence

  sequence s_load_started;
    ##1 load_q ##1 ld_busy;
  endsequence

  AST_LOAD_STARTS: assert property (@(posedge clk) disable iff (!resetn)
    s_load_write |-> s_load_started)
    else $error("load write did not start table load");

  AST_STAT_SET: assert property (@(posedge clk) disable iff (!resetn)
    tbl_entry_write |=> tbl_stat_q)
    else $error("table status not set after entry write");

  AST_STAT_CLR: assert property (@(posedge clk) disable iff (!resetn)
    $fell(tbl_stat_q) |-> $past(ld_done) && !$past(tbl_entry_write))
    else $error("table status cleared without load completion");

  AST_SEL_LEGAL: assert property (@(posedge clk) disable iff (!resetn)
    ctrl_wr && (avs_writedata[19:17] != 3'b011) && avs_byteenable[2] |=> sel_q == ARB_HW_FIXED)
    else $error("illegal arbitration select kept");

  AST_CAP_READ: assert property (@(posedge clk) disable iff (!resetn)
    take && avs_read && avs_address == OFF_CAP |-> avs_readdata == 32'h047F_0009)
    else $error("capability word wrong");

  AST_CTRL_READ: assert property (@(posedge clk) disable iff (!resetn)
    take && avs_read && avs_address == OFF_CTRL |-> avs_readdata[30:8] == {4'h0, 3'h0, 4'h0,
                                                                              3'(sel_q), 1'b0, 8'h00})
    else $error("control readback reserved, id or load bits wrong");

  AST_EN_WRITE: assert property (@(posedge clk) disable iff (!resetn)
    ctrl_wr && avs_byteenable[3] |=> en_q == $past(avs_writedata[31]))
    else $error("enable bit not written");

  // flag must track its input with exactly one register of delay
  AST_NEG: assert property (@(posedge clk) disable iff (!resetn)
    neg_pending_in != neg_q |=> neg_q == $past(neg_pending_in))
    else $error("negotiation flag did not follow its input");

  // the read shows the flag as it stood on the loading edge
  AST_NEG_READ: assert property (@(posedge clk) disable iff (!resetn)
    take && avs_read && avs_address == OFF_STAT |-> avs_readdata[STAT_NEG_BIT] == $past(neg_q))
    else $error("negotiation flag readback wrong");

  AST_WAIT_ONE: assert property (@(posedge clk) disable iff (!resetn)
    $rose(req) |-> avs_waitrequest ##1 !avs_waitrequest)
    else $error("access not answered in one wait cycle");

  // the one other legal scheme must survive the fold
  AST_SEL_KEEP: assert property (@(posedge clk) disable iff (!resetn)
    ctrl_wr && avs_byteenable[2] && (avs_writedata[19:17] == 3'b011) |=> sel_q == ARB_WRR128)
    else $error("legal arbitration select not kept");

  AST_TCMAP_WRITE: assert property (@(posedge clk) disable iff (!resetn)
    ctrl_wr && avs_byteenable[0] |=> tcmap_q == $past(avs_writedata[7:0]))
    else $error("traffic class map not written");

  // takes are never on adjacent edges, so the pulse is one cycle wide
  sequence s_pulse_once;
    ##1 tbl_load_pulse ##1 !tbl_load_pulse;
  endsequence

  AST_PULSE_ONE: assert property (@(posedge clk) disable iff (!resetn)
    load_q |-> s_pulse_once)
    else $error("table load pulse not one cycle");

  // completion with no competing entry write
  sequence s_load_finish;
    ld_done && !tbl_entry_write;
  endsequence

  AST_STAT_DONE: assert property (@(posedge clk) disable iff (!resetn)
    s_load_finish |=> !tbl_stat_q)
    else $error("table status not cleared after load");

  // reserved status bits zero, table flag as loaded into the read register
  AST_STAT_READ: assert property (@(posedge clk) disable iff (!resetn)
    take && avs_read && avs_address == OFF_STAT |-> (avs_readdata[31:18] == 14'h0) &&
      (avs_readdata[15:0] == 16'h0000) && (avs_readdata[STAT_TBL_BIT] == $past(tbl_stat_q)))
    else $error("status readback wrong");

endmodule // vc0_resource_regs

// File: rtl/vc0_tbl_loader.sv
// table load sequencer: counts out the copy of the stored table into the arbiter
`timescale 1ns/1ps
module vc0_tbl_loader
  import vc0_res_pkg::*;
#(
  parameter int LOAD_CYCLES = TBL_LOAD_CYCLES
) (
  input wire logic clk,
  input wire logic resetn,
  input wire logic start,
  output logic busy,
  output logic done
);

  typedef enum logic [0:0] {
    LD_IDLE = 1'b0,
    LD_RUN = 1'b1
  } ld_state_t;

  ld_state_t state_q;
  logic [15:0] cnt_q;

  // sequencer; a start while busy restarts the count so the newest table wins
  always_ff @(posedge clk) begin
    if (!resetn) begin
      state_q <= LD_IDLE;
      cnt_q <= 16'h0000;
      done <= 1'b0;
    end else begin
      done <= 1'b0;
      case (state_q)
        LD_IDLE: begin
          if (start) begin
            state_q <= LD_RUN;
            cnt_q <= 16'(LOAD_CYCLES - 1);
          end
        end
        LD_RUN: begin
          if (start) begin
            cnt_q <= 16'(LOAD_CYCLES - 1);
          end else if (cnt_q == 16'h0000) begin
            state_q <= LD_IDLE;
            done <= 1'b1;
          end else begin
            cnt_q <= cnt_q - 16'h0001;
          end
        end
        default: state_q <= LD_IDLE;
      endcase
    end
  end

  assign busy = (state_q == LD_RUN);

endmodule // vc0_tbl_loader

// File: verif/vc0_resource_regs_test.sv
// self-checking bench for the vc0 resource capability, control and status registers
`timescale 1ns/1ps
module vc0_resource_regs_test;
  import vc0_res_pkg::*;
  // short load count keeps the run brief; expectations derive from it
  localparam int LD = 4;
  logic clk = 1'b0;
  logic resetn = 1'b0;
  logic [11:0] avs_address = 12'h000;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0000_0000;
  logic [3:0] avs_byteenable = 4'hF;
  logic tbl_entry_write = 1'b0;
  logic neg_pending_in = 1'b0;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  vc_ctrl_t vc_ctrl;
  logic tbl_load_pulse;
  int n_errors = 0;
  int tests_run = 0;
  int n_pulses = 0;
  int seed = 98;
  int p;
  logic [31:0] exp_q[$];
  string name_q[$];
  logic [31:0] ctrl_exp;
  logic [31:0] rnd;
  logic [2:0] sel;
  logic [7:0] tc;

  vc0_resource_regs #(.LOAD_CYCLES(LD), .TCMAP_PRELOAD(CTRL_TCMAP_RST)) DUT (
    .clk(clk),
    .resetn(resetn),
    .avs_address(avs_address),
    .avs_read(avs_read),
    .avs_write(avs_write),
    .avs_writedata(avs_writedata),
    .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest),
    .tbl_entry_write(tbl_entry_write),
    .neg_pending_in(neg_pending_in),
    .vc_ctrl(vc_ctrl),
    .tbl_load_pulse(tbl_load_pulse)
  );

  // 200 MHz clock
  always #2.5 clk = ~clk;

  ////////////////////////////////////////////////////////////////////////////////
  // checking and bus tasks
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    tests_run++;
    if (got !== exp) begin
      n_errors++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask

  // one avalon transfer; holds everything until waitrequest is sampled low
  task automatic xfer(input logic wr, input logic [11:0] a, input logic [31:0] d,
                      input logic [3:0] be);
    @(posedge clk);
    avs_address <= a;
    avs_writedata <= d;
    avs_byteenable <= be;
    if (wr) begin
      avs_write <= 1'b1;
    end else begin
      avs_read <= 1'b1;
    end
    // no local limit: only the watchdog ends a hung wait
    do begin
      @(posedge clk);
    end while (avs_waitrequest !== 1'b0);
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [3:0] be);
    xfer(1'b1, a, d, be);
  endtask

  // the expectation is queued before the request so the monitor finds it
  task automatic rd(input logic [11:0] a, input logic [31:0] e, input string what);
    exp_q.push_back(e);
    name_q.push_back(what);
    xfer(1'b0, a, 32'h0000_0000, 4'hF);
  endtask

  task automatic results();
    $display("errors %0d checks %0d", n_errors, tests_run);
    if (n_errors == 0 && tests_run > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // monitor: read data compared at the taking edge, load pulses counted
  always @(posedge clk) begin
    if (avs_read === 1'b1 && avs_waitrequest === 1'b0 && exp_q.size() > 0) begin
      chk(name_q.pop_front(), exp_q.pop_front(), avs_readdata);
    end
    if (tbl_load_pulse === 1'b1) begin
      n_pulses++;
    end
  end

  // watchdog: the sequence needs well under a thousand cycles
  initial begin
    repeat (5000) @(posedge clk);
    n_errors++;
    $display("ERROR watchdog expected done seen timeout");
    results();
  end

  ////////////////////////////////////////////////////////////////////////////////
  // main sequence
  initial begin
    repeat (5) @(posedge clk);
    resetn <= 1'b1;
    rd(OFF_CAP, 32'h047F_0009, "cap");
    rd(OFF_CTRL, 32'h8000_00FF, "ctrl");
    rd(OFF_STAT, 32'h0000_0000, "stat");
    chk("vc_ctrl", {20'h0, 1'b1, ARB_HW_FIXED, 8'hFF}, {20'h0, vc_ctrl});
    // read-only, reserved and unmapped places ignore writes
    wr(OFF_CAP, 32'hFFFF_FFFF, 4'hF);
    wr(OFF_STAT, 32'hFFFF_FFFF, 4'hF);
    wr(12'h15C, 32'hFFFF_FFFF, 4'hF);
    rd(OFF_CAP, 32'h047F_0009, "cap ro");
    rd(OFF_STAT, 32'h0000_0000, "stat ro");
    rd(12'h15C, RD_UNMAPPED, "unmapped");
    // every select code, with reserved bits set and random tc maps
    for (int i = 0; i < 8; i++) begin
      sel = i[2:0];
      rnd = $random(seed);
      tc = rnd[7:0];
      wr(OFF_CTRL, {1'b1, 4'hF, 3'h7, 4'hF, sel, 1'b0, 8'hFF, tc}, 4'hF);
      ctrl_exp = {1'b1, 11'h000, (sel == 3'b011) ? 3'b011 : 3'b000, 9'h000, tc};
      rd(OFF_CTRL, ctrl_exp, "ctrl sel");
      chk("vc_ctrl", {20'h0, 1'b1, ctrl_exp[19:17], tc}, {20'h0, vc_ctrl});
    end
    // single lane write, then channel disable through the top lane
    wr(OFF_CTRL, 32'h0000_005A, 4'h1);
    rd(OFF_CTRL, 32'h8000_005A, "ctrl lane0");
    wr(OFF_CTRL, 32'h0000_0000, 4'h8);
    rd(OFF_CTRL, 32'h0000_005A, "ctrl off");
    chk("vc_ctrl", {20'h0, 1'b0, ARB_HW_FIXED, 8'h5A}, {20'h0, vc_ctrl});
    // table entry write, load, fixed wait of LD + 4 cycles, then one status read
    tbl_entry_write <= 1'b1;
    @(posedge clk);
    tbl_entry_write <= 1'b0;
    rd(OFF_STAT, 32'h0001_0000, "stat written");
    p = n_pulses;
    wr(OFF_CTRL, 32'h0001_0000, 4'h4);
    rd(OFF_STAT, 32'h0001_0000, "stat loading");
    rd(OFF_CTRL, 32'h0000_005A, "ctrl load bit");
    repeat (LD + 4) @(posedge clk);
    rd(OFF_STAT, 32'h0000_0000, "stat loaded");
    chk("load pulses", p + 1, n_pulses);
    // negotiation flag follows its input
    neg_pending_in <= 1'b1;
    rd(OFF_STAT, 32'h0002_0000, "stat neg");
    neg_pending_in <= 1'b0;
    rd(OFF_STAT, 32'h0000_0000, "stat neg done");
    // second reset in mid-run must restore written fields
    resetn <= 1'b0;
    repeat (5) @(posedge clk);
    resetn <= 1'b1;
    rd(OFF_CTRL, 32'h8000_00FF, "ctrl after reset");
    chk("vc_ctrl reset", {20'h0, 1'b1, ARB_HW_FIXED, 8'hFF}, {20'h0, vc_ctrl});
    repeat (3) @(posedge clk);
    results();
  end
endmodule // vc0_resource_regs_test
